/* File: design/seep_cfg.svh */
/*
 Constants of the serial memory command and status logic: opcodes, status
 bit positions, reset values, protection limits and timing counts.
 Assumes it is included by bare name before any use.
*/
`ifndef SEEP_CFG_SVH
`define SEEP_CFG_SVH

// ----------------------------------------------------------------------
// Opcodes: upper nibble zero, bit 3 ignored, low three bits decoded
// ----------------------------------------------------------------------
`define SEEP_OP_HI_ZERO   4'h0
`define SEEP_OP_SET_WEL   3'h6
`define SEEP_OP_CLR_WEL   3'h4
`define SEEP_OP_RD_STAT   3'h5
`define SEEP_OP_WR_STAT   3'h1
`define SEEP_OP_RD_ARR    3'h3
`define SEEP_OP_WR_ARR    3'h2

// ----------------------------------------------------------------------
// Status byte
// ----------------------------------------------------------------------
`define SEEP_BIT_BUSY     0
`define SEEP_BIT_WEL      1
`define SEEP_BIT_BP_LO    2
`define SEEP_BIT_BP_HI    3
`define SEEP_BIT_ARM      7
`define SEEP_STAT_BUSY    8'hFF
`define SEEP_BP_RST       1'h0
`define SEEP_WEL_RST      1'h0
`define SEEP_ARM_RST      1'h0

// ----------------------------------------------------------------------
// Array geometry and protection limits
// ----------------------------------------------------------------------
`define SEEP_ADDR_W       13
`define SEEP_ARR_LAST     13'h1FFF
`define SEEP_PROT_QTR     13'h1800
`define SEEP_PROT_HALF    13'h1000
`define SEEP_IDLE_READ    8'hFF
`define SEEP_FIFO_DEPTH   8
`define SEEP_OP_LAST_BIT  4'h7
`define SEEP_ADDR_LAST_BIT 4'hF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SEEP_CLK_NS       10
`define SEEP_WR_TIME_NS   5000000
`define SEEP_WR_CYCLES    (`SEEP_WR_TIME_NS / `SEEP_CLK_NS)

`endif

/* File: design/seep_pkg.sv */
/*
 Types of the serial memory command and status logic.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package seep_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_OPCODE = 3'h1,
        ST_WAIT   = 3'h2,
        ST_RDSTAT = 3'h3,
        ST_STDATA = 3'h4,
        ST_ADDR   = 3'h5,
        ST_RDARR  = 3'h6,
        ST_WRARR  = 3'h7
    } seep_state_t;

    typedef struct packed {
        logic       hwProtectArm;
        logic [2:0] spare;
        logic       protectLevelHi;
        logic       protectLevelLo;
        logic       writeLatch;
        logic       busy;
    } seep_status_t;

    typedef struct packed {
        logic csN;
        logic sck;
        logic si;
        logic wpN;
    } seep_pins_t;

endpackage : seep_pkg

/* File: design/seep_cmd_status.sv */
/*
 Command decoder, status register, write protection and sequential array
 read of a serial byte-addressed nonvolatile memory, plus its read FIFO.
 Assumes all pins are asynchronous to clk_sys and that the serial clock is
 much slower than clk_sys (at least eight clk_sys periods per sck period).
*/
// Overview of operation
// - Eight-bit status register, read-only when hardware protection active or latch clear.
// - Bit 0 is busy; while busy only read-status is accepted.
// - Bit 1 is write latch; when clear nothing may be modified.
// - Write latch is clear after power-up.
// - Bits 2 and 3 are protect levels, stored and zero from factory.
// - Bits 4 to 6 are not stored and read zero unless busy.
// - Bit 7 arms hardware protection with low protect pin; locks status only.
// - Arm bit cannot go from 1 to 0 while protect pin is low.
// - During internal write every status bit reads one.
// - Levels 00 none, 01 1800h-1FFFh, 11 whole array; protected bytes never change.
// - Block protection applies regardless of arm bit, pin and latch.
// - Select low starts instruction; input sampled on rising clock, MSB first.
// - Output bit changes on each falling serial clock edge.
// - Set latch X110, clear latch X100, read status X101, single byte.
// - Write status X001 plus byte, read X011 and write X010 with address.
// - Clear-latch, write-status and array-write completion clear the latch.
// - Read status repeats the status byte while clocking continues.
// - Write status stores only protect levels and arm bit.
// - Write status ignored unless latch set and hardware protection inactive.
// - Status keeps old values, except busy and write latch, until the write cycle ends.
// - Array read streams sequential bytes and wraps to address zero.
// - Serial link works in clock modes 0 and 3.
// - Select high and idle means standby with output released.
// - Only low 13 address bits select the byte.
`timescale 1ns/1ns
`include "seep_cfg.svh"

module seep_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             flush,
    // Fill side
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    // Drain side
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] memR [DEPTH];
    logic [PW:0]      wrPtrR;
    logic [PW:0]      rdPtrR;
    logic             push;
    logic             pop;

    assign inReady  = (wrPtrR[PW-1:0] != rdPtrR[PW-1:0]) || (wrPtrR[PW] == rdPtrR[PW]);
    assign outValid = (wrPtrR != rdPtrR);
    assign outData  = memR[rdPtrR[PW-1:0]];
    assign push     = inValid && inReady && !flush;
    assign pop      = outValid && outReady && !flush;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPtrR <= '0;
            rdPtrR <= '0;
        end else if (flush) begin
            wrPtrR <= '0;
            rdPtrR <= '0;
        end else begin
            if (push) begin
                wrPtrR <= wrPtrR + (PW+1)'(1);
            end
            if (pop) begin
                rdPtrR <= rdPtrR + (PW+1)'(1);
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (push) begin
            memR[wrPtrR[PW-1:0]] <= inData;
        end
    end
endmodule : seep_fifo

module seep_cmd_status #(
    parameter int WR_CYCLES = `SEEP_WR_CYCLES
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Serial link pins
    input  wire logic csN,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic wpN,
    output logic      soOut,
    output logic      soOeN
);
    localparam int CW = $clog2(WR_CYCLES + 1);
    seep_pkg::seep_pins_t   pinS1R, pinS2R, pinS3R;
    seep_pkg::seep_state_t  stateR;
    seep_pkg::seep_status_t statusNow;
    logic [3:0]             bitCntR;
    logic [7:0]             shInR, opR, stDataR, txR;
    logic [15:0]            addrR;
    logic                   doneR, wrAnyR;
    logic                   wenR, bpHiR, bpLoR, armR, busyR, pendR, pendArmR;
    logic [CW-1:0]          busyCntR;
    logic [2:0]             outCntR;
    logic                   soR, soOeNR, flushR, fetchOnR;
    logic [12:0]            fetchAddrR;
    logic [7:0]             memR [1 << `SEEP_ADDR_W];
    logic                   csActive, csRise, csFall, sckRise, sckFall;
    logic                   wpLow, hwProt, arrWrOk, byteDone, outState;
    logic [7:0]             inByte, outByte;
    logic                   fifoInReady, fifoOutValid, fifoPop;
    logic [7:0]             fifoOutData;

    function automatic logic isOp(input logic [7:0] op, input logic [2:0] code);
        isOp = (op[7:4] == `SEEP_OP_HI_ZERO) && (op[2:0] == code);
    endfunction : isOp
    function automatic logic isProtected(input logic hi, input logic lo, input logic [12:0] a);
        unique case ({hi, lo})
            2'h0: isProtected = 1'b0;
            2'h1: isProtected = (a >= `SEEP_PROT_QTR);
            2'h2: isProtected = (a >= `SEEP_PROT_HALF);
            2'h3: isProtected = 1'b1;
        endcase
    endfunction : isProtected

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pinS1R <= 4'hF;
            pinS2R <= 4'hF;
            pinS3R <= 4'hF;
        end else begin
            pinS1R <= '{csN: csN, sck: sck, si: si, wpN: wpN};
            pinS2R <= pinS1R;
            pinS3R <= pinS2R;
        end
    end

    assign csActive = !pinS2R.csN;
    assign csFall   = !pinS2R.csN && pinS3R.csN;
    assign csRise   = pinS2R.csN && !pinS3R.csN;
    // Edges only count inside a frame, so modes 0 and 3 look alike
    assign sckRise  = csActive && !csFall && pinS2R.sck && !pinS3R.sck;
    assign sckFall  = csActive && !csFall && !pinS2R.sck && pinS3R.sck;
    assign wpLow    = !pinS2R.wpN;
    assign hwProt   = armR && wpLow;
    assign inByte   = {shInR[6:0], pinS2R.si};
    assign byteDone = sckRise && (bitCntR == `SEEP_OP_LAST_BIT);
    // Block levels checked independently of latch and arm
    assign arrWrOk  = wenR && !isProtected(bpHiR, bpLoR, addrR[12:0]);
    assign outState = (stateR == seep_pkg::ST_RDSTAT) || (stateR == seep_pkg::ST_RDARR);

    // ------------------------------------------------------------------
    // Instruction sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stateR  <= seep_pkg::ST_IDLE;
            bitCntR <= 4'h0;
            shInR   <= 8'h00;
            opR     <= 8'h00;
            stDataR <= 8'h00;
            addrR   <= 16'h0000;
            doneR   <= 1'b0;
            wrAnyR  <= 1'b0;
        end else if (!csActive) begin
            stateR  <= seep_pkg::ST_IDLE;
            bitCntR <= 4'h0;
        end else if (csFall) begin
            stateR  <= seep_pkg::ST_OPCODE;
            bitCntR <= 4'h0;
            doneR   <= 1'b0;
            wrAnyR  <= 1'b0;
        end else if (sckRise) begin
            shInR   <= inByte;
            bitCntR <= bitCntR + 4'h1;
            unique case (stateR)
                seep_pkg::ST_OPCODE: begin
                    if (bitCntR == `SEEP_OP_LAST_BIT) begin
                        opR     <= inByte;
                        bitCntR <= 4'h0;
                        doneR   <= !busyR && (isOp(inByte, `SEEP_OP_SET_WEL) ||
                                              isOp(inByte, `SEEP_OP_CLR_WEL));
                        if (isOp(inByte, `SEEP_OP_RD_STAT)) begin
                            stateR <= seep_pkg::ST_RDSTAT;
                        end else if (busyR) begin
                            stateR <= seep_pkg::ST_WAIT;
                        end else if (isOp(inByte, `SEEP_OP_WR_STAT)) begin
                            stateR <= seep_pkg::ST_STDATA;
                        end else if (isOp(inByte, `SEEP_OP_RD_ARR) || isOp(inByte, `SEEP_OP_WR_ARR)) begin
                            stateR <= seep_pkg::ST_ADDR;
                        end else begin
                            stateR <= seep_pkg::ST_WAIT;
                        end
                    end
                end
                seep_pkg::ST_STDATA: begin
                    if (bitCntR == `SEEP_OP_LAST_BIT) begin
                        stDataR <= inByte;
                        doneR   <= 1'b1;
                        stateR  <= seep_pkg::ST_WAIT;
                    end
                end
                seep_pkg::ST_ADDR: begin
                    addrR <= {addrR[14:0], pinS2R.si};
                    if (bitCntR == `SEEP_ADDR_LAST_BIT) begin
                        bitCntR <= 4'h0;
                        stateR  <= isOp(opR, `SEEP_OP_RD_ARR) ? seep_pkg::ST_RDARR : seep_pkg::ST_WRARR;
                    end
                end
                seep_pkg::ST_WRARR: begin
                    if (bitCntR == `SEEP_OP_LAST_BIT) begin
                        bitCntR    <= 4'h0;
                        doneR      <= 1'b1;
                        wrAnyR     <= wrAnyR || arrWrOk;
                        addrR[4:0] <= addrR[4:0] + 5'h01;
                    end
                end
                seep_pkg::ST_RDSTAT, seep_pkg::ST_RDARR, seep_pkg::ST_WAIT, seep_pkg::ST_IDLE: begin
                    bitCntR <= 4'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Status register and internal write cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wenR     <= `SEEP_WEL_RST;
            bpHiR    <= `SEEP_BP_RST;
            bpLoR    <= `SEEP_BP_RST;
            armR     <= `SEEP_ARM_RST;
            busyR    <= 1'b0;
            busyCntR <= '0;
            pendR    <= 1'b0;
            pendArmR <= 1'b0;
        end else if (busyR) begin
            busyCntR <= busyCntR - CW'(1);
            if (busyCntR == CW'(1)) begin
                busyR <= 1'b0;
                pendR <= 1'b0;
                if (pendR) begin
                    // Levels and arm change only now
                    bpHiR <= stDataR[`SEEP_BIT_BP_HI];
                    bpLoR <= stDataR[`SEEP_BIT_BP_LO];
                    armR  <= pendArmR || (armR && wpLow);
                end
            end
        end else if (csRise && doneR) begin
            if (isOp(opR, `SEEP_OP_SET_WEL)) begin
                wenR <= 1'b1;
            end else if (isOp(opR, `SEEP_OP_CLR_WEL)) begin
                wenR <= 1'b0;
            end else if (isOp(opR, `SEEP_OP_WR_STAT)) begin
                wenR <= 1'b0;
                if (wenR && !hwProt) begin
                    busyR    <= 1'b1;
                    busyCntR <= CW'(WR_CYCLES);
                    pendR    <= 1'b1;
                    pendArmR <= stDataR[`SEEP_BIT_ARM];
                end
            end else if (isOp(opR, `SEEP_OP_WR_ARR)) begin
                wenR <= 1'b0;
                if (wrAnyR) begin
                    busyR    <= 1'b1;
                    busyCntR <= CW'(WR_CYCLES);
                end
            end
        end
    end

    // All ones while busy, spare bits zero otherwise
    assign statusNow = busyR ? seep_pkg::seep_status_t'(`SEEP_STAT_BUSY) :
                       seep_pkg::seep_status_t'{hwProtectArm: armR, spare: 3'h0, protectLevelHi: bpHiR,
                         protectLevelLo: bpLoR, writeLatch: wenR, busy: 1'b0};

    // ------------------------------------------------------------------
    // Array storage and read prefetch
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (byteDone && (stateR == seep_pkg::ST_WRARR) && arrWrOk) begin
            memR[addrR[12:0]] <= inByte;
        end
    end

    // Prefetch keeps a few bytes ahead so the falling edge never waits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flushR     <= 1'b1;
            fetchOnR   <= 1'b0;
            fetchAddrR <= 13'h0000;
        end else begin
            flushR <= !csActive;
            if (!csActive) begin
                fetchOnR <= 1'b0;
            end else if (sckRise && (stateR == seep_pkg::ST_ADDR) &&
                         (bitCntR == `SEEP_ADDR_LAST_BIT) && isOp(opR, `SEEP_OP_RD_ARR)) begin
                fetchOnR   <= 1'b1;
                fetchAddrR <= {addrR[11:0], pinS2R.si};
            end else if (fetchOnR && fifoInReady && !flushR) begin
                fetchAddrR <= fetchAddrR + 13'h0001;
            end
        end
    end

    seep_fifo #(
        .WIDTH (8),
        .DEPTH (`SEEP_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .flush    (flushR),
        .inValid  (fetchOnR),
        .inData   (memR[fetchAddrR]),
        .inReady  (fifoInReady),
        .outValid (fifoOutValid),
        .outData  (fifoOutData),
        .outReady (fifoPop)
    );

    // ------------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------------
    assign fifoPop = sckFall && (stateR == seep_pkg::ST_RDARR) && (outCntR == 3'h0);
    assign outByte = (stateR == seep_pkg::ST_RDSTAT) ? statusNow :
                     (fifoOutValid ? fifoOutData : `SEEP_IDLE_READ);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            soR     <= 1'b0;
            soOeNR  <= 1'b1;
            txR     <= 8'h00;
            outCntR <= 3'h0;
        end else begin
            soOeNR <= !(csActive && outState);
            if (!outState) begin
                outCntR <= 3'h0;
            end else if (sckFall) begin
                outCntR <= outCntR + 3'h1;
                if (outCntR == 3'h0) begin
                    // Status reloaded each byte, so it repeats
                    soR <= outByte[7];
                    txR <= {outByte[6:0], 1'b0};
                end else begin
                    soR <= txR[7];
                    txR <= {txR[6:0], 1'b0};
                end
            end
        end
    end

    assign soOut = soR;
    assign soOeN = soOeNR;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_busy_reads_ones: assert property (sckFall && (stateR == seep_pkg::ST_RDSTAT) && busyR
        && outCntR == 3'h0 |=> soR && txR == 8'hFE) else $error("busy status byte not all ones");
    a_busy_only_rdstat: assert property (byteDone && (stateR == seep_pkg::ST_OPCODE) && busyR
        |=> stateR inside {seep_pkg::ST_RDSTAT, seep_pkg::ST_WAIT}) else $error("command accepted while busy");
    a_latch_set_cause: assert property ($rose(wenR)
        |-> $past(csRise) && $past(doneR) && isOp($past(opR), `SEEP_OP_SET_WEL))
        else $error("latch set without command");
    a_latch_cleared: assert property (csRise && doneR && !busyR && !isOp(opR, `SEEP_OP_SET_WEL)
        && !isOp(opR, `SEEP_OP_RD_STAT) |=> !wenR) else $error("latch not cleared on completion");
    a_wrstat_gated: assert property (csRise && doneR && !busyR && isOp(opR, `SEEP_OP_WR_STAT)
        && !(wenR && !hwProt) |=> !busyR ##1 !busyR) else $error("write status not ignored");
    a_status_held: assert property (busyR && $past(busyR)
        |-> $stable({armR, bpHiR, bpLoR})) else $error("status changed during write cycle");
    a_arm_locked: assert property ($fell(armR) |-> !$past(wpLow)) else $error("arm bit dropped with pin low");
    a_full_protect: assert property (bpHiR && bpLoR && (stateR == seep_pkg::ST_WRARR) && !wrAnyR
        |=> !wrAnyR) else $error("protected array accepted a write");
    a_so_on_fall: assert property (!$stable(soR) |-> $past(sckFall)) else $error("output changed off falling edge");
    a_so_released: assert property (!csActive [*2] |-> soOeNR) else $error("output driven in standby");
    a_read_wraps: assert property (fetchOnR && fifoInReady && !flushR && csActive
        && fetchAddrR == `SEEP_ARR_LAST && !sckRise |=> fetchAddrR == 13'h0000) else $error("read did not wrap");
    c_read_status:  cover property (sckFall && (stateR == seep_pkg::ST_RDSTAT) && outCntR == 3'h7);
    c_wrstat_apply: cover property (busyR && pendR ##1 !busyR);
    c_array_wrap:   cover property (fifoPop && fetchAddrR == 13'h0000);
    c_array_write:  cover property (byteDone && (stateR == seep_pkg::ST_WRARR) && arrWrOk);

endmodule : seep_cmd_status

/* File: bench/seep_spi_master.sv */
/*
 Mode 0 or mode 3 SPI master stand-in for the serial memory pins.
 Assumes one frame at a time, link period 80 ns, select idle high.
*/
`timescale 1ns/1ns
module seep_spi_master (
    // Clock
    input  wire logic clk_sys,
    // Serial link pins
    output logic      csN,
    output logic      sck,
    output logic      si,
    input  wire logic soOut,
    input  wire logic soOeN
);
    // Clock level between frames: low for mode 0, high for mode 3
    logic idleHigh = 1'b0;

    initial begin
        csN = 1'b1;
        sck = 1'b0;
        si  = 1'b0;
    end

    // Released output reads as unknown, so a silent device never matches
    task automatic frame(input int nTx, input logic [31:0] tx, input int nRx, output logic [15:0] rx);
        @(posedge clk_sys);
        #1 sck = idleHigh;
        #40 csN = 1'b0;
        #40;
        for (int i = nTx - 1; i >= 0; i--) begin
            sck = 1'b0;
            si  = tx[i];
            #40 sck = 1'b1;
            #40;
        end
        for (int i = nRx - 1; i >= 0; i--) begin
            sck = 1'b0;
            #40 sck = 1'b1;
            #35 rx[i] = (soOeN === 1'b0) ? soOut : 1'bx;
            #5;
        end
        sck = idleHigh;
        #40 csN = 1'b1;
        #100;
    endtask : frame
endmodule : seep_spi_master

/* File: bench/seep_cmd_status_tb.sv */
/*
 Self-checking bench of the serial memory command and status logic.
 Assumes the master model keeps mode 0 or 3 timing; write cycle shortened.
*/
`timescale 1ns/1ns
module seep_cmd_status_tb;
    localparam int         WR_CYC = 400;
    localparam logic [7:0] cmdSetWriteLatch   = 8'h06;
    localparam logic [7:0] cmdClearWriteLatch = 8'h04;
    localparam logic [7:0] cmdReadStatus      = 8'h05;
    localparam logic [7:0] cmdWriteStatus     = 8'h01;
    localparam logic [7:0] cmdReadArray       = 8'h03;
    localparam logic [7:0] cmdWriteArray      = 8'h02;

    logic        clk_sys;
    logic        rst;
    logic        wpN;
    logic        csN;
    logic        sck;
    logic        si;
    logic        soOut;
    logic        soOeN;
    logic [15:0] rx;
    int          numErrors;
    int          cmpCount;

    seep_spi_master m (.clk_sys(clk_sys), .csN(csN), .sck(sck), .si(si), .soOut(soOut), .soOeN(soOeN));
    seep_cmd_status #(.WR_CYCLES(WR_CYC)) dut (.clk_sys(clk_sys), .rst(rst), .csN(csN), .sck(sck),
        .si(si), .wpN(wpN), .soOut(soOut), .soOeN(soOeN));

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            numErrors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cmd(input logic [7:0] op);
        m.frame(8, {24'h0, op}, 0, rx);
    endtask : cmd

    task automatic wrStat(input logic [7:0] d);
        cmd(cmdSetWriteLatch);
        m.frame(16, {16'h0, cmdWriteStatus, d}, 0, rx);
    endtask : wrStat

    // Two bytes out: the second shows the status repeating
    task automatic rdStat(input logic [7:0] exp);
        m.frame(8, {24'h0, cmdReadStatus}, 16, rx);
        check(rx[15:8], exp);
        check(rx[7:0], exp);
    endtask : rdStat

    task automatic waitWr;
        repeat (WR_CYC + 20) @(posedge clk_sys);
    endtask : waitWr

    task automatic wrArr(input logic [15:0] a, input logic [7:0] d);
        cmd(cmdSetWriteLatch);
        m.frame(32, {cmdWriteArray, a, d}, 0, rx);
        waitWr;
    endtask : wrArr

    task automatic rdArr(input logic [15:0] a, input logic [15:0] exp);
        m.frame(24, {8'h0, cmdReadArray, a}, 16, rx);
        check(rx[15:8], exp[15:8]);
        check(rx[7:0], exp[7:0]);
    endtask : rdArr

    task automatic completeRun;
        $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
        if (numErrors == 0 && cmpCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : completeRun

    // ------------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #500000;
        numErrors++;
        $display("Error at %0t: timeout", $time);
        completeRun;
    end

    initial begin
        rst = 1'b1;
        wpN = 1'b1;
        numErrors = 0;
        cmpCount = 0;
        repeat (4) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        check({7'h0, soOeN}, 8'h01);
        rdStat(8'h00);
        m.frame(16, {16'h0, cmdWriteStatus, 8'h8C}, 0, rx);
        rdStat(8'h00);
        cmd(cmdSetWriteLatch);
        rdStat(8'h02);
        cmd(cmdClearWriteLatch);
        rdStat(8'h00);
        $display("latch test done");
        wrStat(8'hFC);
        cmd(cmdSetWriteLatch);
        rdStat(8'hFF);
        waitWr;
        rdStat(8'h8C);
        wpN = 1'b0;
        wrStat(8'h00);
        waitWr;
        rdStat(8'h8C);
        wpN = 1'b1;
        wrStat(8'h00);
        waitWr;
        rdStat(8'h00);
        $display("status test done");
        m.idleHigh = 1'b1;
        cmd(cmdSetWriteLatch);
        rdStat(8'h02);
        cmd(cmdClearWriteLatch);
        rdStat(8'h00);
        m.idleHigh = 1'b0;
        $display("mode 3 test done");
        wrArr(16'hFFFF, 8'h5A);
        wrArr(16'h0000, 8'hC3);
        rdArr(16'h1FFF, 16'h5AC3);
        wrStat(8'h08);
        waitWr;
        wrArr(16'h1FFF, 8'h99);
        wrArr(16'h0000, 8'h77);
        rdArr(16'h1FFF, 16'h5A77);
        wrStat(8'h0C);
        waitWr;
        wrArr(16'h0000, 8'h11);
        rdArr(16'hFFFF, 16'h5A77);
        $display("array test done");
        completeRun;
    end
endmodule : seep_cmd_status_tb
